// ==== logic/config_prom_params.svh ====
`ifndef CONFIG_PROM_PARAMS_SVH
`define CONFIG_PROM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Storage geometry.
// ----------------------------------------------------------------------------
`define ADDR_W 19
`define LAST_ADDRESS 19'h7FFFF
`define BYTE_W 8
`define BIT_IDX_W 3
`define BIT_IDX_LAST 3'h7

// ----------------------------------------------------------------------------
// Instruction register.
// ----------------------------------------------------------------------------
`define IR_W 8
`define IR_CAPTURE 8'h01
`define IR_CODE_LOAD_TARGET 8'hEE

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define MODE_PARALLEL_RESET 1'b0

// ----------------------------------------------------------------------------
// Timing, system clock 200 MHz.
// ----------------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 5
`define RESTART_LOW_MIN_NS 300
`define RESTART_LOW_MAX_NS 500
`define RESTART_CYCLES ((`RESTART_LOW_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define RESTART_CNT_W 7
`define POWERUP_US 1000
`define POWERUP_CYCLES ((`POWERUP_US * 1000) / `SYS_CLK_PERIOD_NS)

`endif

// ==== logic/config_prom_pkg.sv ====
`default_nettype none

package config_prom_pkg;

    typedef enum logic {
        RESTART_IDLE,
        RESTART_PULSE
    } restart_state_t;

endpackage

`default_nettype wire

// ==== logic/config_prom_readout.sv ====
`include "config_prom_params.svh"
`default_nettype none

module config_prom_readout
    import config_prom_pkg::*;
#(
    parameter int POWERUP_CYCLES = `POWERUP_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic TARGET_CONFIG_CLOCK_I,
    input wire logic CHIP_ENABLE_N_I,
    input wire logic OE_RESET_N_I,
    output logic OE_RESET_N_O,
    output logic OE_RESET_N_OE_O,
    output logic [`BYTE_W-1:0] DATA_O,
    output logic [`BYTE_W-1:0] DATA_OE_O,
    output logic CASCADE_ENABLE_OUT_N_O,
    output logic TARGET_RESTART_OUT_N_O,
    input wire logic TAP_STEP_I,
    input wire logic TAP_CAPTURE_IR_I,
    input wire logic TAP_SHIFT_IR_I,
    input wire logic TAP_UPDATE_IR_I,
    input wire logic JTAG_TDI_I,
    output logic JTAG_TDO_O,
    input wire logic MODE_WRITE_I,
    input wire logic MODE_PARALLEL_I,
    input wire logic PROG_WE_I,
    input wire logic [`ADDR_W-1:0] PROG_ADDR_I,
    input wire logic [`BYTE_W-1:0] PROG_DATA_I
);

    // ------------------------------------------------------------------------
    // Storage array, written from the system side, read on the link side.
    // ------------------------------------------------------------------------
    logic [`BYTE_W-1:0] mem [0:`LAST_ADDRESS];

    always_ff @(posedge SYS_CLK_I) begin
        if (PROG_WE_I) begin
            mem[PROG_ADDR_I] <= PROG_DATA_I;
        end
    end

    // ------------------------------------------------------------------------
    // Instruction register and mode control bit.
    // ------------------------------------------------------------------------
    logic [`IR_W-1:0] ir_reg;
    logic mode_parallel_reg;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ir_reg <= `IR_CAPTURE;
        end else if (TAP_STEP_I && TAP_CAPTURE_IR_I) begin
            ir_reg <= `IR_CAPTURE;
        end else if (TAP_STEP_I && TAP_SHIFT_IR_I) begin
            ir_reg <= {JTAG_TDI_I, ir_reg[`IR_W-1:1]};
        end
    end

    assign JTAG_TDO_O = ir_reg[0];

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            mode_parallel_reg <= `MODE_PARALLEL_RESET;
        end else if (MODE_WRITE_I) begin
            mode_parallel_reg <= MODE_PARALLEL_I;
        end
    end

    // ------------------------------------------------------------------------
    // Restart pulse generator.
    // ------------------------------------------------------------------------
    restart_state_t restart_state_reg;
    logic [`RESTART_CNT_W-1:0] restart_cnt_reg;
    logic restart_n_reg;
    logic load_target_cmd;

    assign load_target_cmd = TAP_STEP_I && TAP_UPDATE_IR_I && (ir_reg == `IR_CODE_LOAD_TARGET);

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            restart_state_reg <= RESTART_IDLE;
            restart_cnt_reg <= '0;
            restart_n_reg <= 1'b1;
        end else begin
            case (restart_state_reg)
                RESTART_IDLE: begin
                    if (load_target_cmd) begin
                        restart_state_reg <= RESTART_PULSE;
                        restart_cnt_reg <= `RESTART_CNT_W'(`RESTART_CYCLES - 1);
                        restart_n_reg <= 1'b0;
                    end
                end
                RESTART_PULSE: begin
                    if (restart_cnt_reg == '0) begin
                        restart_state_reg <= RESTART_IDLE;
                        restart_n_reg <= 1'b1;
                    end else begin
                        restart_cnt_reg <= restart_cnt_reg - `RESTART_CNT_W'(1);
                    end
                end
                default: begin
                    restart_state_reg <= RESTART_IDLE;
                    restart_n_reg <= 1'b1;
                end
            endcase
        end
    end

    assign TARGET_RESTART_OUT_N_O = restart_n_reg;

    // ------------------------------------------------------------------------
    // Power-up hold of the output-enable/reset pin.
    // ------------------------------------------------------------------------
    logic [31:0] powerup_cnt_reg;
    logic ready_reg;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            powerup_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!ready_reg) begin
            if (powerup_cnt_reg >= 32'(POWERUP_CYCLES - 1)) begin
                ready_reg <= 1'b1;
            end
            powerup_cnt_reg <= powerup_cnt_reg + 32'h1;
        end
    end

    assign OE_RESET_N_O = 1'b0;
    assign OE_RESET_N_OE_O = !ready_reg;

    // ------------------------------------------------------------------------
    // Crossings into the configuration clock domain.
    // ------------------------------------------------------------------------
    logic [4:0] link_sync1_reg;
    logic [4:0] link_sync2_reg;
    logic link_rst;
    logic ready_link;
    logic mode_parallel_link;
    logic chip_enable_n_link;
    logic oe_reset_n_link;

    always_ff @(posedge TARGET_CONFIG_CLOCK_I) begin
        link_sync1_reg <= {RST_I, ready_reg, mode_parallel_reg, CHIP_ENABLE_N_I, OE_RESET_N_I};
        link_sync2_reg <= link_sync1_reg;
    end

    assign link_rst = link_sync2_reg[4];
    assign ready_link = link_sync2_reg[3];
    assign mode_parallel_link = link_sync2_reg[2];
    assign chip_enable_n_link = link_sync2_reg[1];
    assign oe_reset_n_link = link_sync2_reg[0];

    // ------------------------------------------------------------------------
    // Address and bit counters.
    // ------------------------------------------------------------------------
    logic hold;
    logic active_reg;
    logic past_end_reg;
    logic [`ADDR_W-1:0] addr_reg;
    logic [`BIT_IDX_W-1:0] bit_reg;
    logic past_end_next;
    logic [`ADDR_W-1:0] addr_next;
    logic [`BIT_IDX_W-1:0] bit_next;

    // Output-enable/reset has a fixed active-low sense; chip enable high is standby.
    assign hold = link_rst || !ready_link || !oe_reset_n_link || chip_enable_n_link;

    always_comb begin
        addr_next = addr_reg;
        bit_next = bit_reg;
        past_end_next = past_end_reg;
        if (hold) begin
            addr_next = '0;
            bit_next = '0;
            past_end_next = 1'b0;
        end else if (active_reg && !past_end_reg) begin
            if (mode_parallel_link || bit_reg == `BIT_IDX_LAST) begin
                bit_next = '0;
                if (addr_reg == `LAST_ADDRESS) begin
                    past_end_next = 1'b1;
                end else begin
                    addr_next = addr_reg + `ADDR_W'(1);
                end
            end else begin
                bit_next = bit_reg + `BIT_IDX_W'(1);
            end
        end
    end

    always_ff @(posedge TARGET_CONFIG_CLOCK_I) begin
        if (link_rst) begin
            active_reg <= 1'b0;
            past_end_reg <= 1'b0;
            addr_reg <= '0;
            bit_reg <= '0;
        end else begin
            active_reg <= !hold;
            past_end_reg <= past_end_next;
            addr_reg <= addr_next;
            bit_reg <= bit_next;
        end
    end

    // ------------------------------------------------------------------------
    // Data, enables and cascade output.
    // ------------------------------------------------------------------------
    logic [`BYTE_W-1:0] data_reg;
    logic [`BYTE_W-1:0] data_oe_reg;
    logic cascade_n_reg;
    logic [`BYTE_W-1:0] rd_byte;
    logic drive;

    assign rd_byte = mem[addr_next];
    assign drive = !hold && !past_end_next;

    always_ff @(posedge TARGET_CONFIG_CLOCK_I) begin
        if (link_rst) begin
            data_reg <= '0;
            data_oe_reg <= '0;
        end else if (!drive) begin
            data_reg <= '0;
            data_oe_reg <= '0;
        end else if (mode_parallel_link) begin
            data_reg <= rd_byte;
            data_oe_reg <= '1;
        end else begin
            // Serial data leaves most significant bit first on the lowest data line.
            data_reg <= {{(`BYTE_W - 1){1'b0}}, rd_byte[`BIT_IDX_LAST - bit_next]};
            data_oe_reg <= `BYTE_W'(1);
        end
    end

    always_ff @(posedge TARGET_CONFIG_CLOCK_I) begin
        if (link_rst) begin
            cascade_n_reg <= 1'b1;
        end else begin
            cascade_n_reg <= hold || !past_end_next;
        end
    end

    assign DATA_O = data_reg;
    assign DATA_OE_O = data_oe_reg;
    assign CASCADE_ENABLE_OUT_N_O = cascade_n_reg;

    // ------------------------------------------------------------------------
    // Assertions, system clock domain.
    // ------------------------------------------------------------------------
    localparam int LOW_LEN_W = `RESTART_CNT_W + 1;
    logic [`RESTART_CNT_W:0] low_len_reg;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || restart_n_reg) begin
            low_len_reg <= '0;
        end else begin
            low_len_reg <= low_len_reg + LOW_LEN_W'(1);
        end
    end

    property p_restart_width;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(restart_n_reg) |-> $past(low_len_reg) == LOW_LEN_W'(`RESTART_CYCLES - 1);
    endproperty
    a_restart_width: assert property (p_restart_width) else $error("restart pulse width wrong");

    property p_restart_cause;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(restart_n_reg) |-> $past(load_target_cmd);
    endproperty
    a_restart_cause: assert property (p_restart_cause) else $error("restart without command");

    property p_restart_start;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (load_target_cmd && restart_n_reg) |=> !restart_n_reg [*8];
    endproperty
    a_restart_start: assert property (p_restart_start) else $error("restart pulse did not start");

    property p_powerup_hold;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (powerup_cnt_reg < 32'(POWERUP_CYCLES - 1)) |=> OE_RESET_N_OE_O;
    endproperty
    a_powerup_hold: assert property (p_powerup_hold) else $error("reset pin released early");

    property p_mode_write;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        MODE_WRITE_I |=> mode_parallel_reg == $past(MODE_PARALLEL_I);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bit not written");

    property p_ir_shift;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        (TAP_STEP_I && TAP_SHIFT_IR_I && !TAP_CAPTURE_IR_I) |=>
            ir_reg == {$past(JTAG_TDI_I), $past(ir_reg[`IR_W-1:1])};
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");

    c_restart: cover property (@(posedge SYS_CLK_I) disable iff (RST_I) $rose(restart_n_reg));

    // ------------------------------------------------------------------------
    // Assertions, configuration clock domain.
    // ------------------------------------------------------------------------
    property p_hold_clears;
        @(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        hold |=> (addr_reg == '0) && cascade_n_reg && (data_oe_reg == '0);
    endproperty
    a_hold_clears: assert property (p_hold_clears) else $error("hold did not clear state");

    property p_advance;
        @(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        (!hold && active_reg && !past_end_reg && mode_parallel_link && addr_reg < `LAST_ADDRESS) |=>
            addr_reg == $past(addr_reg) + `ADDR_W'(1);
    endproperty
    a_advance: assert property (p_advance) else $error("address did not advance");

    property p_past_end;
        @(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        (past_end_reg && !hold) |=> past_end_reg && !cascade_n_reg && (data_oe_reg == '0) && $stable(addr_reg);
    endproperty
    a_past_end: assert property (p_past_end) else $error("past-terminal state lost");

    property p_serial_one_line;
        @(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        !mode_parallel_link |=> data_oe_reg[`BYTE_W-1:1] == '0;
    endproperty
    a_serial_one_line: assert property (p_serial_one_line) else $error("serial mode drives extra lines");

    c_past_end: cover property (@(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst) $fell(cascade_n_reg));
    c_parallel: cover property (@(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        mode_parallel_link && data_oe_reg == '1);
    c_serial: cover property (@(posedge TARGET_CONFIG_CLOCK_I) disable iff (link_rst)
        !mode_parallel_link && data_oe_reg[0]);

endmodule

`default_nettype wire

// ==== tb/config_target_model.sv ====
`default_nettype none

// ----------------------------------------------------------------------------
// Target device seen from the memory: clock source, init and completion lines.
// ----------------------------------------------------------------------------
module config_target_model (
    output logic cfg_clk_o,
    output logic init_low_o,
    output logic done_n_o,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] bus;

    // Released data lines float up to the target's pull-ups.
    assign bus = (data_i & data_oe_i) | ~data_oe_i;

    initial begin
        cfg_clk_o = 1'b0;
        init_low_o = 1'b1;
        done_n_o = 1'b1;
    end

    // Init drives the shared output-enable/reset line, completion drives chip enable.
    task automatic set_lines(input logic init_low, input logic ce_n);
        init_low_o = init_low;
        done_n_o = ce_n;
    endtask

    // One configuration clock cycle of 15 ns, off the system clock grid.
    task automatic pulse(output logic [7:0] seen, output logic [7:0] seen_oe);
        #1.3;
        cfg_clk_o = 1'b1;
        #7.5;
        seen = bus;
        seen_oe = data_oe_i;
        cfg_clk_o = 1'b0;
        #6.2;
    endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
`include "config_prom_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PU = 20;
    localparam int LIMIT = 20000;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_clk, init_low, ce_n, oe_pin, oe_drv, oe_en, tdo, casc_n, restart_n;
    logic [`BYTE_W-1:0] data, data_oe, s0, s1;
    logic step = 1'b0, cap = 1'b0, shift = 1'b0, upd = 1'b0, tdi = 1'b0;
    logic mode_wr = 1'b0, mode_par = 1'b0, prog_we = 1'b0;
    logic [`ADDR_W-1:0] prog_addr = '0;
    logic [`BYTE_W-1:0] prog_data = 8'h00;
    logic [7:0] img [3] = '{8'hA5, 8'h3C, 8'h0F};
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    // The shared reset line has a pull-up; either party may pull it low.
    assign oe_pin = !((oe_en && !oe_drv) || init_low);

    always #2.5 sys_clk = ~sys_clk;

    config_target_model i_tgt (.cfg_clk_o(cfg_clk), .init_low_o(init_low), .done_n_o(ce_n),
        .data_i(data), .data_oe_i(data_oe));

    config_prom_readout #(.POWERUP_CYCLES(PU)) i_dut (.SYS_CLK_I(sys_clk), .RST_I(rst),
        .TARGET_CONFIG_CLOCK_I(cfg_clk), .CHIP_ENABLE_N_I(ce_n), .OE_RESET_N_I(oe_pin),
        .OE_RESET_N_O(oe_drv), .OE_RESET_N_OE_O(oe_en), .DATA_O(data), .DATA_OE_O(data_oe),
        .CASCADE_ENABLE_OUT_N_O(casc_n), .TARGET_RESTART_OUT_N_O(restart_n), .TAP_STEP_I(step),
        .TAP_CAPTURE_IR_I(cap), .TAP_SHIFT_IR_I(shift), .TAP_UPDATE_IR_I(upd), .JTAG_TDI_I(tdi),
        .JTAG_TDO_O(tdo), .MODE_WRITE_I(mode_wr), .MODE_PARALLEL_I(mode_par), .PROG_WE_I(prog_we),
        .PROG_ADDR_I(prog_addr), .PROG_DATA_I(prog_data));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    // One test clock edge; steps stay at least 100 ns apart.
    task automatic tap_op(input logic c, input logic s, input logic u, input logic d);
        repeat (20) @(negedge sys_clk);
        {cap, shift, upd, tdi, step} = {c, s, u, d, 1'b1};
        @(negedge sys_clk);
        {cap, shift, upd, step} = 4'h0;
        repeat (2) @(negedge sys_clk);
    endtask

    // Reads units from address zero once the memory starts driving.
    task automatic read_start(input logic par, input int nbytes);
        logic [7:0] seen, seen_oe, exp;
        int k;
        k = 0;
        i_tgt.pulse(seen, seen_oe);
        while (seen_oe === 8'h00 && k < 6) begin
            i_tgt.pulse(seen, seen_oe);
            k++;
        end
        for (int u = 0; u < (par ? nbytes : nbytes * 8); u++) begin
            exp = par ? img[u] : {7'h7F, img[u / 8][7 - u % 8]};
            check("data", seen, exp);
            check("data enable", seen_oe, par ? 8'hFF : 8'h01);
            check("cascade", {7'h0, casc_n}, 8'h01);
            i_tgt.pulse(seen, seen_oe);
        end
    endtask

    // Holds the counter through one control line, then reads again from the start.
    task automatic t_hold(input logic init_l, input logic ce_hi, input logic par);
        i_tgt.set_lines(init_l, ce_hi);
        repeat (3) i_tgt.pulse(s0, s1);
        check("held enable", data_oe, 8'h00);
        check("held cascade", {7'h0, casc_n}, 8'h01);
        i_tgt.set_lines(1'b0, 1'b0);
        read_start(par, 2);
    endtask

    task automatic t_powerup();
        int n;
        check("power-up hold", {7'h0, oe_en}, 8'h01);
        check("restart idle", {7'h0, restart_n}, 8'h01);
        for (int a = 0; a < 3; a++) begin
            @(negedge sys_clk);
            {prog_we, prog_addr, prog_data} = {1'b1, 19'(a), img[a]};
        end
        @(negedge sys_clk);
        prog_we = 1'b0;
        i_tgt.set_lines(1'b0, 1'b0);
        check("reset pin level", {7'h0, oe_pin}, 8'h00);
        i_tgt.pulse(s0, s1);
        check("enable in power-up", s1, 8'h00);
        n = 0;
        while (oe_en === 1'b1 && n < PU + 10) begin
            @(negedge sys_clk);
            n++;
        end
        check("power-up length", 8'((n > PU - 12) && (n < PU + 3)), 8'h01);
    endtask

    task automatic t_restart();
        logic [7:0] ir;
        logic [7:0] code;
        logic prev;
        int lo, falls;
        ir = `IR_CAPTURE;
        code = `IR_CODE_LOAD_TARGET;
        tap_op(1'b1, 1'b0, 1'b0, 1'b0);
        check("tdo capture", {7'h0, tdo}, {7'h0, ir[0]});
        for (int i = 0; i < `IR_W; i++) begin
            ir = {code[i], ir[7:1]};
            tap_op(1'b0, 1'b1, 1'b0, ir[7]);
            check("tdo shift", {7'h0, tdo}, {7'h0, ir[0]});
        end
        {lo, falls, prev} = {32'd0, 32'd0, 1'b1};
        for (int c = 0; c < 200; c++) begin
            {upd, step} = {2{c == 0 || c == 30}};
            @(negedge sys_clk);
            lo += (restart_n === 1'b0);
            falls += (prev === 1'b1 && restart_n === 1'b0);
            prev = restart_n;
        end
        check("restart width", 8'(lo >= 60 && lo <= 100), 8'h01);
        check("restart count", 8'(falls), 8'h01);
    endtask

    initial begin
        fork
            repeat (6) @(negedge sys_clk);
            repeat (4) i_tgt.pulse(s0, s1);
        join
        @(negedge sys_clk);
        rst = 1'b0;
        t_powerup();
        read_start(1'b0, 2);
        t_hold(1'b1, 1'b0, 1'b0);
        t_hold(1'b0, 1'b1, 1'b0);
        @(negedge sys_clk);
        {mode_wr, mode_par} = 2'b11;
        @(negedge sys_clk);
        mode_wr = 1'b0;
        t_hold(1'b0, 1'b1, 1'b1);
        t_restart();
        close_out();
    end
endmodule

`default_nettype wire
